// *** logic/uorc_pkg.sv ***
// Package and pin synchroniser for the USB soft-reset and global interrupt block.
// Behaviour
// - Full-speed core reset idles its machines, self-clears.
// - Full-speed core reset bit clears within cycles.
// - Controller reset clears flags, registers, keeps three.
// - Controller reset idles machines and flushes FIFOs.
// - Bus master data phase finishes first.
// - Ongoing USB transaction aborts at once.
// - Controller reset bit self-clears after variable time.
// - Status register shows current host or device role.
// - FIFO flags read-only, withdrawn on FIFO access.
// - Wakeup flag sets on resume or remote wakeup.
// - Disconnect flag sets in host role only.
// - Connector ID flag sets on any change.
// - Bit 31 shows bus master idle.
package uorc_pkg;

  localparam int          ADDR_W            = 12;
  localparam logic [11:0] OFS_RESET_CTRL    = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS    = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK      = 12'h008;
  localparam logic [11:0] OFS_CORE_CONFIG   = 12'h00c;

  localparam int RST_CSR_BIT  = 0;
  localparam int RST_FS_BIT   = 1;
  localparam int RST_IDLE_BIT = 31;

  localparam int STS_MODE_BIT  = 0;
  localparam int STS_RXNE_BIT  = 4;
  localparam int STS_PTXE_BIT  = 26;
  localparam int STS_CONID_BIT = 28;
  localparam int STS_DISC_BIT  = 29;
  localparam int STS_WAKE_BIT  = 31;
  localparam logic [31:0] STS_W1C_MASK = 32'hb000_0000;
  localparam logic [31:0] STS_RESET    = 32'h0000_0000;

  localparam int CFG_LSCLK_LSB = 0;
  localparam int CFG_SPEED_LSB = 2;
  localparam int CFG_SDIS_BIT  = 4;
  localparam int CFG_TUNE_LSB  = 5;
  localparam logic [31:0] CFG_KEEP_MASK = 32'h0000_001f;
  localparam logic [31:0] CFG_RW_MASK   = 32'h0000_00ff;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SYNC_W = 4;

  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int PHY_CLK_PERIOD_NS  = 21;
  localparam int PHY_SYNC_CLOCKS    = 3;
  localparam int CSR_HOLD_CYCLES    = (PHY_SYNC_CLOCKS * PHY_CLK_PERIOD_NS + CORE_CLK_PERIOD_NS - 1)
                                      / CORE_CLK_PERIOD_NS;
  localparam int FS_RST_CYCLES      = 4;
  localparam logic [3:0] CSR_HOLD_LAST = 4'(CSR_HOLD_CYCLES - 1);
  localparam logic [3:0] FS_RST_LOAD   = 4'(FS_RST_CYCLES);

  typedef enum logic [1:0] {RS_IDLE, RS_DRAIN, RS_HOLD} uorc_rst_state_type;

  function automatic logic uorc_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [31:0] uorc_strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

`timescale 1ns/100ps
`default_nettype none

module uorc_sync3 import uorc_pkg::*; (
  // Clock, enable and reset.
  input  wire logic              clk,
  input  wire logic              clk_en,
  input  wire logic              rst,
  // Raw pins and filtered levels.
  input  wire logic [SYNC_W-1:0] pin_in,
  output logic      [SYNC_W-1:0] level_out
);

  logic [SYNC_W-1:0] stage1_q;
  logic [SYNC_W-1:0] stage2_q;
  logic [SYNC_W-1:0] stage3_q;

  // A level is accepted once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q  <= 4'h0;
      stage2_q  <= 4'h0;
      stage3_q  <= 4'h0;
      level_out <= 4'h0;
    end else if (clk_en) begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      for (int i = 0; i < SYNC_W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          level_out[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** logic/uorc_top.sv ***
// Soft-reset control, global interrupt status and their register slave.
`timescale 1ns/100ps
`default_nettype none

module uorc_top import uorc_pkg::*; (
  // Clock, enable and reset.
  input  wire logic              CORE_CLK,
  input  wire logic              CLK_EN,
  input  wire logic              SYS_RST,
  // Register bus write channels.
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // Register bus read channels.
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Line events from the PHY side.
  input  wire logic              PIN_RESUME_DET,
  input  wire logic              PIN_DISCONNECT_DET,
  input  wire logic              PIN_CONN_ID,
  input  wire logic              PIN_HOST_ROLE,
  // Controller status on this clock.
  input  wire logic              MASTER_IDLE,
  input  wire logic              MASTER_DATA_PHASE,
  input  wire logic              PTX_FIFO_EMPTY,
  input  wire logic              RX_FIFO_NONEMPTY,
  input  wire logic              TX_FIFO_ACCESS,
  input  wire logic              RX_FIFO_ACCESS,
  // Reset and configuration outputs to the controller.
  output logic                   CTRL_RESET,
  output logic                   FIFO_FLUSH,
  output logic                   USB_ABORT,
  output logic                   FS_CORE_RESET,
  output logic [1:0]             CFG_LS_CLK_SEL,
  output logic [1:0]             CFG_DEV_SPEED,
  output logic                   CFG_SOFT_DISCONNECT,
  output logic [2:0]             CFG_PHY_TUNE,
  // Interrupt.
  output logic                   IRQ
);

  logic [SYNC_W-1:0]  pins_s;
  logic [5:0]         prev_q;
  logic               resume_s;
  logic               disc_s;
  logic               conn_id_s;
  logic               host_role_s;
  logic               wake_rise;
  logic               disc_rise;
  logic               conid_chg;
  logic               ptx_rise;
  logic               rxne_rise;

  logic               aw_got_q;
  logic               w_got_q;
  logic [ADDR_W-1:0]  awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [1:0]         rresp_q;
  logic [31:0]        rdata_q;
  logic               wr_fire;
  logic               rd_fire;
  logic [31:0]        wr_bits;

  uorc_rst_state_type rst_state_q;
  logic [3:0]         hold_cnt_q;
  logic [3:0]         fs_cnt_q;
  logic               hold;
  logic               csr_req;
  logic               fs_req;
  logic               fs_active;

  logic [31:0]        sts_q;
  logic [31:0]        sts_set;
  logic [31:0]        sts_clr;
  logic [31:0]        sts_view;
  logic [31:0]        mask_q;
  logic [31:0]        cfg_q;
  logic               irq_q;

  uorc_sync3 u_sync (
    .clk       (CORE_CLK),
    .clk_en    (CLK_EN),
    .rst       (SYS_RST),
    .pin_in    ({PIN_HOST_ROLE, PIN_CONN_ID, PIN_DISCONNECT_DET, PIN_RESUME_DET}),
    .level_out (pins_s)
  );

  assign resume_s    = pins_s[0];
  assign disc_s      = pins_s[1];
  assign conn_id_s   = pins_s[2];
  assign host_role_s = pins_s[3];

  // Previous levels for edge detection.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prev_q <= 6'h00;
    end else if (CLK_EN) begin
      prev_q <= {RX_FIFO_NONEMPTY, PTX_FIFO_EMPTY, pins_s};
    end
  end

  assign wake_rise = uorc_rise(resume_s, prev_q[0]);
  assign disc_rise = uorc_rise(disc_s, prev_q[1]) & host_role_s;
  assign conid_chg = conn_id_s ^ prev_q[2];
  assign ptx_rise  = uorc_rise(PTX_FIFO_EMPTY, prev_q[4]);
  assign rxne_rise = uorc_rise(RX_FIFO_NONEMPTY, prev_q[5]);

  // Write path: address and data are taken in either order.
  assign S_AXI_AWREADY = ~aw_got_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_got_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign wr_fire       = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_bits       = wdata_q & uorc_strb_mask(wstrb_q);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        if (awaddr_q == OFS_RESET_CTRL || awaddr_q == OFS_IRQ_STATUS ||
            awaddr_q == OFS_IRQ_MASK || awaddr_q == OFS_CORE_CONFIG) begin
          bresp_q <= RESP_OKAY;
        end else begin
          bresp_q <= RESP_SLVERR;
        end
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read path: one read at a time, data registered at the address handshake.
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign rd_fire       = S_AXI_ARVALID & ~rvalid_q;
  assign sts_view      = sts_q | {31'h0000_0000, host_role_s};

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        if (S_AXI_ARADDR == OFS_RESET_CTRL) begin
          rdata_q <= {MASTER_IDLE, 28'h000_0000, 1'b0, fs_active, ~hold_idle()};
        end else if (S_AXI_ARADDR == OFS_IRQ_STATUS) begin
          rdata_q <= sts_view;
        end else if (S_AXI_ARADDR == OFS_IRQ_MASK) begin
          rdata_q <= mask_q;
        end else if (S_AXI_ARADDR == OFS_CORE_CONFIG) begin
          rdata_q <= cfg_q;
        end else begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  function automatic logic hold_idle();
    return rst_state_q == RS_IDLE;
  endfunction

  // Controller soft reset sequencer.
  assign csr_req = wr_fire & (awaddr_q == OFS_RESET_CTRL) & wr_bits[RST_CSR_BIT];
  assign hold    = rst_state_q == RS_HOLD;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rst_state_q <= RS_IDLE;
      hold_cnt_q  <= 4'h0;
    end else if (CLK_EN) begin
      case (rst_state_q)
        RS_IDLE: begin
          hold_cnt_q <= 4'h0;
          if (csr_req) begin
            rst_state_q <= RS_DRAIN;
          end
        end
        RS_DRAIN: begin
          if (!MASTER_DATA_PHASE) begin
            rst_state_q <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          if (hold_cnt_q == CSR_HOLD_LAST) begin
            rst_state_q <= RS_IDLE;
          end else begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end
        end
        default: begin
          rst_state_q <= RS_IDLE;
        end
      endcase
    end
  end

  assign USB_ABORT  = ~hold_idle();
  assign CTRL_RESET = hold;
  assign FIFO_FLUSH = hold;

  // Full-speed core reset: a short self-clearing pulse.
  assign fs_req    = wr_fire & (awaddr_q == OFS_RESET_CTRL) & wr_bits[RST_FS_BIT];
  assign fs_active = fs_cnt_q != 4'h0;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fs_cnt_q <= 4'h0;
    end else if (CLK_EN) begin
      if (hold) begin
        fs_cnt_q <= 4'h0;
      end else if (fs_req && !fs_active) begin
        fs_cnt_q <= FS_RST_LOAD;
      end else if (fs_active) begin
        fs_cnt_q <= fs_cnt_q - 4'h1;
      end
    end
  end

  assign FS_CORE_RESET = fs_active;

  // Interrupt status: hardware sets, software clears, set wins.
  always_comb begin
    sts_set                = 32'h0000_0000;
    sts_set[STS_WAKE_BIT]  = wake_rise;
    sts_set[STS_DISC_BIT]  = disc_rise;
    sts_set[STS_CONID_BIT] = conid_chg;
    sts_set[STS_PTXE_BIT]  = ptx_rise;
    sts_set[STS_RXNE_BIT]  = rxne_rise;
    sts_clr                = 32'h0000_0000;
    if (wr_fire && awaddr_q == OFS_IRQ_STATUS) begin
      sts_clr = wr_bits & STS_W1C_MASK;
    end
    if (rd_fire && S_AXI_ARADDR == OFS_IRQ_STATUS) begin
      sts_clr = sts_clr | STS_W1C_MASK;
    end
    sts_clr[STS_PTXE_BIT] = TX_FIFO_ACCESS;
    sts_clr[STS_RXNE_BIT] = RX_FIFO_ACCESS;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sts_q <= STS_RESET;
    end else if (CLK_EN) begin
      if (hold) begin
        sts_q <= STS_RESET;
      end else begin
        sts_q <= (sts_q & ~sts_clr) | sts_set;
      end
    end
  end

  // Mask and configuration registers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mask_q <= 32'h0000_0000;
      cfg_q  <= CFG_RESET;
    end else if (CLK_EN) begin
      if (hold) begin
        mask_q <= 32'h0000_0000;
        cfg_q  <= cfg_q & CFG_KEEP_MASK;
      end else if (wr_fire) begin
        if (awaddr_q == OFS_IRQ_MASK) begin
          mask_q <= (mask_q & ~uorc_strb_mask(wstrb_q)) | wr_bits;
        end else if (awaddr_q == OFS_CORE_CONFIG) begin
          cfg_q <= ((cfg_q & ~uorc_strb_mask(wstrb_q)) | wr_bits) & CFG_RW_MASK;
        end
      end
    end
  end

  assign CFG_LS_CLK_SEL      = cfg_q[CFG_LSCLK_LSB +: 2];
  assign CFG_DEV_SPEED       = cfg_q[CFG_SPEED_LSB +: 2];
  assign CFG_SOFT_DISCONNECT = cfg_q[CFG_SDIS_BIT];
  assign CFG_PHY_TUNE        = cfg_q[CFG_TUNE_LSB +: 3];

  // Level interrupt from any unmasked sticky bit; the role bit is not an event.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else if (CLK_EN) begin
      irq_q <= |(sts_q & mask_q & ~32'h0000_0001);
    end
  end

  assign IRQ = irq_q;

  default clocking uorc_cb @(posedge CORE_CLK iff CLK_EN);
  endclocking
  default disable iff (SYS_RST);

  chk_fs_pulse_len: assert property (
    $rose(FS_CORE_RESET) |-> FS_CORE_RESET[*4] ##1 !FS_CORE_RESET
  ) else $error("Full-speed core reset pulse has wrong length.");

  chk_fs_reset_start: assert property (
    (fs_req && !fs_active && !hold) |=> FS_CORE_RESET
  ) else $error("Full-speed core reset did not start.");

  chk_csr_hold_len: assert property (
    $rose(CTRL_RESET) |-> CTRL_RESET[*7] ##1 (!CTRL_RESET && !USB_ABORT)
  ) else $error("Controller reset hold has wrong length.");

  chk_drain_first: assert property (
    $rose(CTRL_RESET) |-> !$past(MASTER_DATA_PHASE)
  ) else $error("Controller reset began during a data phase.");

  chk_abort_now: assert property (
    (csr_req && hold_idle()) |=> USB_ABORT
  ) else $error("USB transaction not aborted at once.");

  chk_flush_with_reset: assert property (
    $rose(CTRL_RESET) |-> FIFO_FLUSH && $past(USB_ABORT)
  ) else $error("FIFO flush missing during controller reset.");

  chk_reset_clears_regs: assert property (
    $fell(CTRL_RESET) |-> (sts_q == STS_RESET) && (mask_q == 32'h0000_0000) && (CFG_PHY_TUNE == 3'h0)
  ) else $error("Controller reset left registers set.");

  chk_reset_keeps_cfg: assert property (
    CTRL_RESET |=> $stable(CFG_LS_CLK_SEL) && $stable(CFG_DEV_SPEED) && $stable(CFG_SOFT_DISCONNECT)
  ) else $error("Controller reset changed a kept field.");

  chk_role_readback: assert property (
    (rd_fire && S_AXI_ARADDR == OFS_IRQ_STATUS) |=> S_AXI_RDATA[STS_MODE_BIT] == $past(host_role_s)
  ) else $error("Role bit does not match current role.");

  chk_fifo_withdraw: assert property (
    (TX_FIFO_ACCESS && !ptx_rise) |=> !sts_q[STS_PTXE_BIT]
  ) else $error("FIFO flag not withdrawn on access.");

  chk_wake_set: assert property (
    (wake_rise && !hold) |=> sts_q[STS_WAKE_BIT]
  ) else $error("Wakeup flag not set.");

  chk_disc_host_only: assert property (
    $rose(sts_q[STS_DISC_BIT]) |-> $past(host_role_s)
  ) else $error("Disconnect flag set outside host role.");

  chk_conid_set: assert property (
    (conid_chg && !hold) |=> sts_q[STS_CONID_BIT]
  ) else $error("Connector ID change flag not set.");

  chk_clear_set_wins: assert property (
    (sts_clr[STS_WAKE_BIT] && wake_rise && !hold) |=> sts_q[STS_WAKE_BIT]
  ) else $error("Clear won over a new wakeup event.");

  chk_idle_readback: assert property (
    (rd_fire && S_AXI_ARADDR == OFS_RESET_CTRL) |=> S_AXI_RDATA[RST_IDLE_BIT] == $past(MASTER_IDLE)
  ) else $error("Idle bit does not show bus master idle.");

endmodule

`default_nettype wire

// *** verification/uorc_peer.sv ***
// Behavioural USB line peer that drives the event and role pins of the block.
`timescale 1ns/100ps
`default_nettype none

module uorc_peer (
  // Clock.
  input  wire logic clk,
  // Line pins towards the block.
  output logic      resume_pin,
  output logic      disc_pin,
  output logic      id_pin,
  output logic      host_pin
);
  initial begin
    resume_pin = 1'b0;
    disc_pin   = 1'b0;
    id_pin     = 1'b0;
    host_pin   = 1'b0;
  end

  // Holds a pin long enough for the pin filter, then lets a resume or disconnect pin fall again; the ID pin stays toggled.
  task automatic line_event(input int kind);
    @(posedge clk);
    case (kind)
      0: resume_pin <= 1'b1;
      1: disc_pin <= 1'b1;
      default: id_pin <= ~id_pin;
    endcase
    repeat (6) @(posedge clk);
    resume_pin <= 1'b0;
    disc_pin   <= 1'b0;
  endtask

  // Switches the attached role between host and device.
  task automatic set_role(input logic host);
    @(posedge clk);
    host_pin <= host;
  endtask
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the soft-reset and global interrupt block.
`timescale 1ns/100ps
`default_nettype none

module testbench import uorc_pkg::*;;
  logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic              idle, dphase, rx_ne, rx_acc, bvalid, rvalid, awready, wready, arready;
  logic              resume_pin, disc_pin, id_pin, host_pin;
  logic              hold, flush, abort, fs_rst, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_v;
  logic [1:0]        bresp, rresp, b_v, r_v;
  int                errors, checked, fs_cnt, hold_cnt, flush_cnt;
  logic              clk_en, ptx_e, tx_acc, sdis_o;
  logic [3:0]        strb;
  logic [1:0]        ls_o, spd_o;
  logic [2:0]        tune_o;

  uorc_peer u_uorc_peer (.clk(clk), .resume_pin(resume_pin), .disc_pin(disc_pin), .id_pin(id_pin),
    .host_pin(host_pin));

  uorc_top u_uorc_top (.CORE_CLK(clk), .CLK_EN(clk_en), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_RESUME_DET(resume_pin), .PIN_DISCONNECT_DET(disc_pin), .PIN_CONN_ID(id_pin),
    .PIN_HOST_ROLE(host_pin), .MASTER_IDLE(idle), .MASTER_DATA_PHASE(dphase), .PTX_FIFO_EMPTY(ptx_e),
    .RX_FIFO_NONEMPTY(rx_ne), .TX_FIFO_ACCESS(tx_acc), .RX_FIFO_ACCESS(rx_acc), .CTRL_RESET(hold),
    .FIFO_FLUSH(flush), .USB_ABORT(abort), .FS_CORE_RESET(fs_rst), .CFG_LS_CLK_SEL(ls_o),
    .CFG_DEV_SPEED(spd_o), .CFG_SOFT_DISCONNECT(sdis_o), .CFG_PHY_TUNE(tune_o), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts the cycles for which FS_CORE_RESET, CTRL_RESET and FIFO_FLUSH stand high; USB_ABORT is not counted.
  always @(negedge clk) begin
    fs_cnt    += int'(fs_rst);
    hold_cnt  += int'(hold);
    flush_cnt += int'(flush);
  end

  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n rising edges, then stops on a falling edge where outputs are settled.
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do begin
      @(negedge clk);
    end while (!bvalid);
    b_v = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
    end while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
    end while (!rvalid);
    rd_v = rdata;
    r_v  = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    rd(a);
    cmp(rd_v, exp);
  endtask

  task automatic init_regs();
    rd(OFS_IRQ_STATUS);
    wr(OFS_IRQ_STATUS, 32'hffff_ffff);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    rchk(OFS_RESET_CTRL, 32'h8000_0000);
    idle <= 1'b0;
    rchk(OFS_RESET_CTRL, 32'h0000_0000);
    idle <= 1'b1;
    wr(12'h010, 32'h0000_0001);
    cmp(32'(b_v), 32'(RESP_SLVERR));
    rd(12'h010);
    cmp(32'(r_v), 32'(RESP_SLVERR));
    cmp(rd_v, 32'h0000_0000);
  endtask

  task automatic fs_reset();
    fs_cnt = 0;
    wr(OFS_RESET_CTRL, 32'h0000_0002);
    wait_n(8);
    cmp(32'(fs_cnt), 32'd4);
    rchk(OFS_RESET_CTRL, 32'h8000_0000);
    fs_cnt = 0;
    wr(OFS_RESET_CTRL, 32'h0000_0002);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    wait_n(8);
    cmp(32'(fs_cnt), 32'd7);
  endtask

  task automatic line_flags();
    u_uorc_peer.line_event(1);
    wait_n(10);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    u_uorc_peer.set_role(1'b1);
    wait_n(6);
    u_uorc_peer.line_event(1);
    wait_n(10);
    rchk(OFS_IRQ_STATUS, 32'h2000_0001);
    u_uorc_peer.line_event(0);
    wait_n(10);
    rchk(OFS_IRQ_STATUS, 32'h8000_0001);
    u_uorc_peer.set_role(1'b0);
    wait_n(6);
    u_uorc_peer.line_event(0);
    wait_n(10);
    rchk(OFS_IRQ_STATUS, 32'h8000_0000);
    u_uorc_peer.line_event(2);
    wait_n(10);
    rchk(OFS_IRQ_STATUS, 32'h1000_0000);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    // The status read lands in the very cycle of the wakeup edge.
    fork
      u_uorc_peer.line_event(0);
      begin
        repeat (4) @(posedge clk);
        rd(OFS_IRQ_STATUS);
      end
    join
    cmp(rd_v, 32'h0000_0000);
    rchk(OFS_IRQ_STATUS, 32'h8000_0000);
  endtask

  task automatic irq_w1c();
    wr(OFS_IRQ_MASK, 32'h1000_0000);
    u_uorc_peer.line_event(2);
    wait_n(10);
    cmp(32'(irq), 32'h1);
    wr(OFS_IRQ_STATUS, 32'h0000_0000);
    wait_n(2);
    cmp(32'(irq), 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1000_0000);
    wait_n(2);
    cmp(32'(irq), 32'h0);
  endtask

  task automatic fifo_flag();
    @(posedge clk);
    rx_ne <= 1'b1;
    ptx_e <= 1'b1;
    wait_n(3);
    rchk(OFS_IRQ_STATUS, 32'h0400_0010);
    rx_acc <= 1'b1;
    @(posedge clk);
    rx_acc <= 1'b0;
    wait_n(1);
    rchk(OFS_IRQ_STATUS, 32'h0400_0000);
    tx_acc <= 1'b1;
    @(posedge clk);
    tx_acc <= 1'b0;
    wait_n(1);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    rx_ne <= 1'b0;
    ptx_e <= 1'b0;
  endtask

  task automatic ctrl_reset();
    wr(OFS_CORE_CONFIG, 32'h0000_00ff);
    wait_n(1);
    cmp(32'({tune_o, sdis_o, spd_o, ls_o}), 32'h0000_00ff);
    strb <= 4'h8;
    wr(OFS_IRQ_MASK, 32'hffff_ffff);
    strb <= 4'hf;
    rchk(OFS_IRQ_MASK, 32'hff00_0000);
    u_uorc_peer.line_event(2);
    dphase <= 1'b1;
    wait_n(10);
    cmp(32'(irq), 32'h1);
    hold_cnt  = 0;
    flush_cnt = 0;
    wr(OFS_RESET_CTRL, 32'h0000_0001);
    wait_n(4);
    cmp(32'(hold), 32'h0);
    cmp(32'(abort), 32'h1);
    rchk(OFS_RESET_CTRL, 32'h8000_0001);
    dphase <= 1'b0;
    wait_n(20);
    cmp(32'(hold_cnt), 32'd7);
    cmp(32'(flush_cnt), 32'd7);
    cmp(32'(abort), 32'h0);
    cmp(32'(irq), 32'h0);
    rchk(OFS_RESET_CTRL, 32'h8000_0000);
    wait_n(3);
    rchk(OFS_CORE_CONFIG, 32'h0000_001f);
    cmp(32'({tune_o, sdis_o, spd_o, ls_o}), 32'h0000_001f);
    rchk(OFS_IRQ_MASK, 32'h0000_0000);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
  endtask

  initial begin
    errors  = 0;
    checked = 0;
    rst     = 1'b1;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    idle    = 1'b1;
    dphase  = 1'b0;
    rx_ne   = 1'b0;
    rx_acc  = 1'b0;
    clk_en  = 1'b1;
    ptx_e   = 1'b0;
    tx_acc  = 1'b0;
    strb    = 4'hf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_n(4);
    init_regs();
    fs_reset();
    line_flags();
    irq_w1c();
    fifo_flag();
    ctrl_reset();
    wrap_up();
  end

  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
